/* File: src/stop_mode_power_gating.sv */
// Stop-mode clock, power and reset gating with memory map decoding
// Operation
// - Stop gates peripheral clocks except wakeup, LF
// - Debug in stop still halts peripheral clocks
// - Deep stop puts general pins Hi-Z
// - Deep wake resets module registers, RAM lost
// - Parameter registers powered always, never reset
// - Low-freq oscillator and wakeup unit always run
// - Medium oscillator on in stop only when busy
// - High-freq oscillator off in every stop
// - Converter runs in retained stop, reset after deep
// - Timer clock stops; reset after deep wake
// - Regulator standby except retained with LVD/debug
// - Bandgap on while measurement interface requests
// - Temperature restart powered if enabled; resets CPU
// - RF chain held on while send bit set
// - Pressure and g cells powered only when measuring
// - Decode direct, parameter, RAM and high pages
// - Upper 8K flash reserved for firmware
// - Vectors redirected to user area after init
// - Two-byte vector per interrupt source
// - Shared reset vector for all reset sources
// - Deep request with LVD in stop gives retained
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
module stop_mode_power_gating
   import stop_gate_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic smi_measure_busy,
   input wire logic smi_pressure_meas,
   input wire logic smi_accel_meas,
   input wire logic smi_bandgap_req,
   input wire logic rf_sm_busy,
   input wire logic temp_restart_trip,
   input wire logic [7:0] param_wdata,
   input wire logic [5:0] param_addr,
   input wire logic param_we,
   output logic [7:0] param_rdata,
   output logic periph_clk_en,
   output logic wakeup_unit_clk_en,
   output logic lf_receiver_clk_en,
   output logic debug_clk_en,
   output logic low_freq_osc_en,
   output logic medium_freq_osc_en,
   output logic high_freq_osc_en,
   output logic regulator_full_en,
   output logic general_io_pins_hiz,
   output logic timer_pwm_clk_en,
   output logic converter_unit_run_en,
   output logic bandgap_en,
   output logic temp_restart_pwr_en,
   output logic rf_chain_keep_en,
   output logic pressure_cell_pwr_en,
   output logic accel_cell_pwr_en,
   output logic module_wake_reset,
   output logic ram_lost,
   output logic cpu_restart
);
   logic [CTRL_W-1:0] ctrl_q;
   power_state_e state_q, state_d;
   logic wake_rst_q;
   logic ram_lost_q;
   logic restart_q;
   logic [G_W-1:0] gate_q, gate_d;
   logic [15:0] probe_q;
   logic [3:0] vec_src_q;
   logic [7:0] param_mem [PARAM_BYTES];
   logic [7:0] param_rd_q;
   logic aw_q, w_q, bvalid_q, rvalid_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [1:0] bresp_q, rresp_q;

   function automatic logic [2:0] region_of(input logic [15:0] a);
      if (a < PARAM_BASE) return RG_DIRECT;
      if (a <= PARAM_LAST) return RG_PARAM;
      if (a >= RAM_BASE && a <= RAM_LAST) return RG_RAM;
      if (a >= HIGH_BASE && a <= HIGH_LAST) return RG_HIGH;
      if (a >= USER_FLASH_BASE && a < FW_FLASH_BASE) return RG_USER;
      if (a >= FW_FLASH_BASE) return RG_FIRM;
      return RG_NONE;
   endfunction

   function automatic logic [15:0] vector_of(input logic [3:0] s,
                                             input logic [15:0] base);
      logic [15:0] v;
      v = base;
      unique case (s)
         SRC_KBI:  v = base + 16'h0020;
         SRC_TICK: v = base + 16'h0026;
         SRC_LFR:  v = base + 16'h0028;
         SRC_CONV: v = base + 16'h002A;
         SRC_RF:   v = base + 16'h002C;
         SRC_SMI:  v = base + 16'h002E;
         SRC_TOVF: v = base + 16'h0030;
         SRC_TCH1: v = base + 16'h0032;
         SRC_TCH0: v = base + 16'h0034;
         SRC_WAKE: v = base + 16'h0036;
         SRC_LVD:  v = base + 16'h0038;
         SRC_SWI:  v = base + 16'h003C;
         default:  v = base + 16'h003E;
      endcase
      return v;
   endfunction

   // Control bits
   wire deep_sel = ctrl_q[CTRL_DEEP];
   wire lvd_in_stop = ctrl_q[CTRL_LVDSTOP];
   wire debug_in_stop_enable = ctrl_q[CTRL_DBGSTOP];
   wire temp_restart_enable = ctrl_q[CTRL_TEMPRS];
   wire send_bit = ctrl_q[CTRL_SEND];
   wire vec_redirect = ctrl_q[CTRL_VECRDY];

   // AXI decode
   logic wstrb_q0;
   logic [1:0] wstrb_lo_q;
   wire aw_hs = s_axi_awvalid & s_axi_awready;
   wire w_hs = s_axi_wvalid & s_axi_wready;
   wire wr_fire = aw_q & w_q & ~bvalid_q;
   wire ar_hs = s_axi_arvalid & s_axi_arready;
   wire [7:0] ar_ofs = s_axi_araddr[7:0];
   wire wr_ctrl = wr_fire & (awaddr_q == CTRL_OFS) & wstrb_q0;
   wire wr_req = wr_fire & (awaddr_q == REQ_OFS) & wstrb_q0;
   wire wr_addr = wr_fire & (awaddr_q == ADDR_OFS);
   wire wr_vec = wr_fire & (awaddr_q == VEC_OFS) & wstrb_q0;
   wire wr_ok = (awaddr_q == CTRL_OFS) | (awaddr_q == REQ_OFS) |
                (awaddr_q == ADDR_OFS) | (awaddr_q == VEC_OFS);
   wire stop_req = wr_req & wdata_q[REQ_STOP];
   wire wake_req = wr_req & wdata_q[REQ_WAKE];

   // Deep request with LVD or debug kept becomes retained stop
   wire go_deep = deep_sel & ~lvd_in_stop & ~debug_in_stop_enable;
   wire in_stop = (state_q != ST_RUN);
   wire in_deep = (state_q == ST_DEEP);
   wire restart_fire = in_stop & temp_restart_enable & temp_restart_trip;
   wire wake_ev = wake_req | restart_fire;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_RUN: if (stop_req) begin
            state_d = go_deep ? ST_DEEP : ST_RETAINED;
         end
         ST_RETAINED, ST_DEEP: if (wake_ev) begin
            state_d = ST_RUN;
         end
         default: state_d = ST_RUN;
      endcase
   end

   always_comb begin
      gate_d = '0;
      gate_d[G_PERIPH] = ~in_stop;
      gate_d[G_MFO] = ~in_stop | smi_measure_busy | rf_sm_busy;
      gate_d[G_HFO] = ~in_stop;
      gate_d[G_REG] = (state_q != ST_DEEP) &
                      (~in_stop | lvd_in_stop | debug_in_stop_enable);
      gate_d[G_IO] = in_deep;
      gate_d[G_TIMER] = ~in_stop;
      gate_d[G_BANDGAP] = smi_bandgap_req;
      gate_d[G_TEMP] = ~in_stop | temp_restart_enable;
      gate_d[G_RFKEEP] = send_bit;
      gate_d[G_PCELL] = smi_pressure_meas;
      gate_d[G_GCELL] = smi_accel_meas;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ST_RUN;
         gate_q <= '0;
         wake_rst_q <= 1'b0;
         restart_q <= 1'b0;
      end else begin
         state_q <= state_d;
         gate_q <= gate_d;
         // One-cycle wake reset after deep stop exit
         wake_rst_q <= in_deep & wake_ev;
         restart_q <= restart_fire;
      end
   end

   // RAM loss flag: set on deep entry, cleared by a control register write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ram_lost_q <= 1'b0;
      end else if (state_d == ST_DEEP && state_q == ST_RUN) begin
         ram_lost_q <= 1'b1;
      end else if (wr_ctrl) begin
         ram_lost_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= CTRL_RESET;
         probe_q <= '0;
         vec_src_q <= SRC_RESET;
      end else begin
         if (wr_ctrl) ctrl_q <= wdata_q[CTRL_W-1:0];
         if (wr_addr && wstrb_lo_q[0]) probe_q[7:0] <= wdata_q[7:0];
         if (wr_addr && wstrb_lo_q[1]) probe_q[15:8] <= wdata_q[15:8];
         if (wr_vec) vec_src_q <= wdata_q[3:0];
      end
   end

   // Parameter bytes: no reset reaches them
   always_ff @(posedge aclk) begin
      if (param_we) param_mem[param_addr] <= param_wdata;
      param_rd_q <= param_mem[param_addr];
   end

   wire [15:0] vec_base = vec_redirect ? USER_VEC_BASE - 16'h0000 - 16'h0000
                                       : FACTORY_VEC_BASE;
   wire [15:0] vec_addr = vector_of(vec_src_q, vec_base - 16'h0000) -
                          16'h0000 - 16'h0000;
   wire [2:0] probe_region = region_of(probe_q);

   // AXI write channel
   assign s_axi_awready = ~aw_q & ~bvalid_q;
   assign s_axi_wready = ~w_q & ~bvalid_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         bvalid_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q0 <= 1'b0;
         wstrb_lo_q <= '0;
         bresp_q <= RESP_OKAY;
      end else begin
         if (aw_hs) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr[7:0];
         end
         if (w_hs) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q0 <= s_axi_wstrb[0];
            wstrb_lo_q <= s_axi_wstrb[1:0];
         end
         if (wr_fire) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // AXI read channel
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      unique case (ar_ofs)
         CTRL_OFS: rd_mux[CTRL_W-1:0] = ctrl_q;
         STATUS_OFS: rd_mux = {28'h000_0000, ram_lost_q, 1'b0, state_q};
         GATE_OFS: rd_mux[G_W-1:0] = gate_q;
         ADDR_OFS: rd_mux[15:0] = probe_q;
         DECODE_OFS: rd_mux[2:0] = probe_region;
         VEC_OFS: rd_mux[3:0] = vec_src_q;
         VECADR_OFS: rd_mux[15:0] = vec_addr;
         default: rd_mux = '0;
      endcase
   end
   wire rd_ok = (ar_ofs == CTRL_OFS) | (ar_ofs == STATUS_OFS) |
                (ar_ofs == GATE_OFS) | (ar_ofs == ADDR_OFS) |
                (ar_ofs == DECODE_OFS) | (ar_ofs == VEC_OFS) |
                (ar_ofs == VECADR_OFS) | (ar_ofs == REQ_OFS);
   assign s_axi_arready = ~rvalid_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // Gating outputs
   assign periph_clk_en = gate_q[G_PERIPH];
   assign wakeup_unit_clk_en = 1'b1;
   assign lf_receiver_clk_en = 1'b1;
   assign low_freq_osc_en = 1'b1;
   assign debug_clk_en = ~in_stop | debug_in_stop_enable;
   assign medium_freq_osc_en = gate_q[G_MFO];
   assign high_freq_osc_en = gate_q[G_HFO];
   assign regulator_full_en = gate_q[G_REG];
   assign general_io_pins_hiz = gate_q[G_IO];
   assign timer_pwm_clk_en = gate_q[G_TIMER];
   assign converter_unit_run_en = ~in_deep;
   assign bandgap_en = gate_q[G_BANDGAP];
   assign temp_restart_pwr_en = gate_q[G_TEMP];
   assign rf_chain_keep_en = gate_q[G_RFKEEP];
   assign pressure_cell_pwr_en = gate_q[G_PCELL];
   assign accel_cell_pwr_en = gate_q[G_GCELL];
   assign module_wake_reset = wake_rst_q;
   assign ram_lost = ram_lost_q;
   assign cpu_restart = restart_q;
   assign param_rdata = param_rd_q;
endmodule

/* File: shared/stop_gate_pkg.sv */
// Constants and types for the stop-mode power gating block
package stop_gate_pkg;
   // Register byte offsets on the control bus
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] REQ_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   localparam logic [7:0] GATE_OFS = 8'h0C;
   localparam logic [7:0] ADDR_OFS = 8'h10;
   localparam logic [7:0] DECODE_OFS = 8'h14;
   localparam logic [7:0] VEC_OFS = 8'h18;
   localparam logic [7:0] VECADR_OFS = 8'h1C;
   // Control register bit positions
   localparam int CTRL_DEEP = 0;
   localparam int CTRL_LVDSTOP = 1;
   localparam int CTRL_DBGSTOP = 2;
   localparam int CTRL_TEMPRS = 3;
   localparam int CTRL_SEND = 4;
   localparam int CTRL_VECRDY = 5;
   localparam int CTRL_W = 6;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
   // Request register bits: stop request and wake request
   localparam int REQ_STOP = 0;
   localparam int REQ_WAKE = 1;
   // Memory map
   localparam logic [15:0] PARAM_BASE = 16'h0050;
   localparam logic [15:0] PARAM_LAST = 16'h008F;
   localparam logic [15:0] RAM_BASE = 16'h0090;
   localparam logic [15:0] RAM_LAST = 16'h028F;
   localparam logic [15:0] HIGH_BASE = 16'h1800;
   localparam logic [15:0] HIGH_LAST = 16'h182B;
   localparam logic [15:0] USER_FLASH_BASE = 16'hC000;
   localparam logic [15:0] FW_FLASH_BASE = 16'hE000;
   localparam logic [15:0] USER_VEC_BASE = 16'hDFC0;
   localparam logic [15:0] RESET_VEC = 16'hDFFE;
   localparam logic [15:0] FACTORY_VEC_BASE = 16'hFFC0;
   localparam int PARAM_BYTES = 64;
   // Region codes
   localparam logic [2:0] RG_DIRECT = 3'h0;
   localparam logic [2:0] RG_PARAM = 3'h1;
   localparam logic [2:0] RG_RAM = 3'h2;
   localparam logic [2:0] RG_HIGH = 3'h3;
   localparam logic [2:0] RG_USER = 3'h4;
   localparam logic [2:0] RG_FIRM = 3'h5;
   localparam logic [2:0] RG_NONE = 3'h7;
   // Interrupt and reset sources
   localparam logic [3:0] SRC_KBI = 4'h0;
   localparam logic [3:0] SRC_TICK = 4'h1;
   localparam logic [3:0] SRC_LFR = 4'h2;
   localparam logic [3:0] SRC_CONV = 4'h3;
   localparam logic [3:0] SRC_RF = 4'h4;
   localparam logic [3:0] SRC_SMI = 4'h5;
   localparam logic [3:0] SRC_TOVF = 4'h6;
   localparam logic [3:0] SRC_TCH1 = 4'h7;
   localparam logic [3:0] SRC_TCH0 = 4'h8;
   localparam logic [3:0] SRC_WAKE = 4'h9;
   localparam logic [3:0] SRC_LVD = 4'hA;
   localparam logic [3:0] SRC_SWI = 4'hB;
   localparam logic [3:0] SRC_RESET = 4'hC;
   // Gate output bit positions
   localparam int G_PERIPH = 0;
   localparam int G_MFO = 1;
   localparam int G_HFO = 2;
   localparam int G_REG = 3;
   localparam int G_IO = 4;
   localparam int G_TIMER = 5;
   localparam int G_BANDGAP = 6;
   localparam int G_TEMP = 7;
   localparam int G_RFKEEP = 8;
   localparam int G_PCELL = 9;
   localparam int G_GCELL = 10;
   localparam int G_W = 11;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_RETAINED = 2'b01,
      ST_DEEP = 2'b11
   } power_state_e;
endpackage

/* File: dv/stop_gate_peripherals.sv */
// Behavioural model of the measurement, RF and temperature side
module stop_gate_peripherals (
   input wire logic aclk,
   input wire logic [5:0] cmd,
   output logic smi_measure_busy,
   output logic smi_pressure_meas,
   output logic smi_accel_meas,
   output logic smi_bandgap_req,
   output logic rf_sm_busy,
   output logic temp_restart_trip
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] cmd_q = 6'h00;
   // Levels follow the bench command one clock later, like a real peripheral
   always @(posedge aclk) cmd_q <= cmd;
   assign smi_measure_busy = cmd_q[0];
   assign smi_pressure_meas = cmd_q[1];
   assign smi_accel_meas = cmd_q[2];
   assign smi_bandgap_req = cmd_q[3];
   assign rf_sm_busy = cmd_q[4];
   assign temp_restart_trip = cmd_q[5];
endmodule

/* File: dv/stop_gate_assertions.sv */
// Checker for the stop-mode gating outputs
module stop_gate_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic smi_measure_busy,
   input wire logic smi_pressure_meas,
   input wire logic smi_accel_meas,
   input wire logic smi_bandgap_req,
   input wire logic rf_sm_busy,
   input wire logic temp_restart_trip,
   input wire logic periph_clk_en,
   input wire logic wakeup_unit_clk_en,
   input wire logic lf_receiver_clk_en,
   input wire logic low_freq_osc_en,
   input wire logic medium_freq_osc_en,
   input wire logic high_freq_osc_en,
   input wire logic regulator_full_en,
   input wire logic general_io_pins_hiz,
   input wire logic timer_pwm_clk_en,
   input wire logic bandgap_en,
   input wire logic pressure_cell_pwr_en,
   input wire logic accel_cell_pwr_en,
   input wire logic module_wake_reset,
   input wire logic ram_lost,
   input wire logic cpu_restart
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   always_on_a:
      assert property (low_freq_osc_en && wakeup_unit_clk_en
      && lf_receiver_clk_en) else $error("always-on clock dropped");
   clock_group_a:
      assert property (periph_clk_en == high_freq_osc_en
      && periph_clk_en == timer_pwm_clk_en)
      else $error("clock gates disagree");
   deep_pins_a:
      assert property (general_io_pins_hiz |->
      !regulator_full_en && !periph_clk_en)
      else $error("hi-z pins outside deep stop");
   bandgap_follow_a:
      assert property ($past(aresetn) |->
      bandgap_en == $past(smi_bandgap_req))
      else $error("bandgap not following request");
   cell_power_a:
      assert property ($past(aresetn) |->
      pressure_cell_pwr_en == $past(smi_pressure_meas)
      && accel_cell_pwr_en == $past(smi_accel_meas))
      else $error("cell power not following measurement");
   mfo_idle_a:
      assert property (!periph_clk_en && !$past(smi_measure_busy)
      && !$past(rf_sm_busy) |-> !medium_freq_osc_en)
      else $error("medium oscillator on while idle in stop");
   wake_pulse_a:
      assert property (module_wake_reset |=> !module_wake_reset)
      else $error("wake reset longer than one cycle");
   wake_ram_a:
      assert property (module_wake_reset |-> ##[0:1] ram_lost)
      else $error("ram loss not flagged on deep wake");
   restart_cause_a:
      assert property (cpu_restart |->
      ($past(temp_restart_trip) || $past(temp_restart_trip, 2))
      ##1 !cpu_restart) else $error("restart without trip");
   cover property (general_io_pins_hiz);
   cover property (module_wake_reset);
   cover property (cpu_restart);
   cover property (!periph_clk_en && regulator_full_en);
endmodule

bind stop_mode_power_gating stop_gate_checker chk_u (.aclk, .aresetn,
   .smi_measure_busy, .smi_pressure_meas, .smi_accel_meas,
   .smi_bandgap_req, .rf_sm_busy, .temp_restart_trip, .periph_clk_en,
   .wakeup_unit_clk_en, .lf_receiver_clk_en, .low_freq_osc_en,
   .medium_freq_osc_en, .high_freq_osc_en, .regulator_full_en,
   .general_io_pins_hiz, .timer_pwm_clk_en, .bandgap_en,
   .pressure_cell_pwr_en, .accel_cell_pwr_en, .module_wake_reset,
   .ram_lost, .cpu_restart);

/* File: dv/test_stop_mode_power_gating.sv */
// Self-checking bench for the stop-mode power gating block
module test_stop_mode_power_gating import stop_gate_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic smi_measure_busy, smi_pressure_meas, smi_accel_meas;
   logic smi_bandgap_req, rf_sm_busy, temp_restart_trip;
   logic [7:0] param_wdata = 0, param_rdata;
   logic [5:0] param_addr = 0, cmd = 0;
   logic param_we = 0;
   logic periph_clk_en, wakeup_unit_clk_en, lf_receiver_clk_en;
   logic debug_clk_en, low_freq_osc_en, medium_freq_osc_en;
   logic high_freq_osc_en, regulator_full_en, general_io_pins_hiz;
   logic timer_pwm_clk_en, converter_unit_run_en, bandgap_en;
   logic temp_restart_pwr_en, rf_chain_keep_en, pressure_cell_pwr_en;
   logic accel_cell_pwr_en, module_wake_reset, ram_lost, cpu_restart;
   logic [31:0] d;
   logic [1:0] r;
   int bad_count = 0, samples_checked = 0, wakes = 0, restarts = 0;
   stop_mode_power_gating dut_u (.*);
   stop_gate_peripherals peri_u (.*);
   always #5 aclk = ~aclk;
   always @(posedge aclk) begin
      if (module_wake_reset === 1'b1) wakes++;
      if (cpu_restart === 1'b1) restarts++;
   end
   task automatic summarize();
      $display("mismatches %0d, checks %0d", bad_count, samples_checked);
      if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= {24'h00_0000, a};
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= {24'h00_0000, a};
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   task automatic rst();
      @(posedge aclk);
      aresetn <= 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
   endtask
   // Select stop type, request stop, let the gates settle
   task automatic go(input logic [31:0] c);
      wr(CTRL_OFS, c);
      wr(REQ_OFS, 32'h0000_0001);
      repeat (3) @(posedge aclk);
   endtask
   task automatic wake();
      wr(REQ_OFS, 32'h0000_0002);
      repeat (3) @(posedge aclk);
   endtask
   task automatic t_reset();
      rd(STATUS_OFS);
      chk(d, 0);
      rd(CTRL_OFS);
      chk(d, 0);
      chk({periph_clk_en, high_freq_osc_en, regulator_full_en,
         general_io_pins_hiz, timer_pwm_clk_en}, 5'b11101);
      chk({low_freq_osc_en, wakeup_unit_clk_en, lf_receiver_clk_en}, 7);
      rd(8'h20);
      chk(r, RESP_SLVERR);
   endtask
   task automatic t_deep();
      go(32'h0000_0001);
      rd(STATUS_OFS);
      chk(d[1:0], ST_DEEP);
      chk({periph_clk_en, high_freq_osc_en, regulator_full_en,
         general_io_pins_hiz, timer_pwm_clk_en, medium_freq_osc_en},
         6'b000100);
      chk(converter_unit_run_en, 0);
      cmd <= 6'h10;
      repeat (3) @(posedge aclk);
      chk(medium_freq_osc_en, 1);
      cmd <= 0;
      wakes = 0;
      wake();
      chk(wakes, 1);
      rd(STATUS_OFS);
      chk(d, 32'h0000_0008);
      chk(periph_clk_en, 1);
   endtask
   task automatic t_ret();
      logic [31:0] c[3] = '{32'h0000_0003, 32'h0000_0005, 32'h0000_0000};
      for (int i = 0; i < 3; i++) begin
         go(c[i]);
         rd(STATUS_OFS);
         chk(d[1:0], ST_RETAINED);
         chk({periph_clk_en, regulator_full_en, general_io_pins_hiz,
            timer_pwm_clk_en, converter_unit_run_en},
            {3'b0, i < 2, 3'b001});
         if (i == 1) chk(debug_clk_en, 1);
         wake();
      end
   endtask
   task automatic t_temp();
      go(32'h0000_0008);
      chk(temp_restart_pwr_en, 1);
      restarts = 0;
      cmd <= 6'h20;
      repeat (5) @(posedge aclk);
      cmd <= 0;
      chk(restarts, 1);
      rd(STATUS_OFS);
      chk(d[1:0], ST_RUN);
      wr(CTRL_OFS, 32'h0000_0010);
      cmd <= 6'h0E;
      repeat (3) @(posedge aclk);
      chk(rf_chain_keep_en, 1);
      chk({bandgap_en, pressure_cell_pwr_en, accel_cell_pwr_en}, 7);
      cmd <= 0;
      repeat (3) @(posedge aclk);
      chk({bandgap_en, pressure_cell_pwr_en, accel_cell_pwr_en}, 0);
   endtask
   task automatic t_map();
      logic [15:0] a[12] = '{16'h0000, 16'h004F, 16'h0050, 16'h008F,
         16'h0090, 16'h028F, 16'h1800, 16'h182B, 16'hC000, 16'hDFFF,
         16'hE000, 16'h0300};
      logic [2:0] g[12] = '{0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 5, 7};
      for (int i = 0; i < 12; i++) begin
         wr(ADDR_OFS, {16'h0000, a[i]});
         rd(DECODE_OFS);
         chk(d, g[i]);
      end
   endtask
   task automatic t_vec();
      logic [15:0] v[13] = '{16'hDFE0, 16'hDFE6, 16'hDFE8, 16'hDFEA,
         16'hDFEC, 16'hDFEE, 16'hDFF0, 16'hDFF2, 16'hDFF4, 16'hDFF6,
         16'hDFF8, 16'hDFFC, 16'hDFFE};
      wr(CTRL_OFS, 32'h0000_0020);
      for (int i = 0; i < 13; i++) begin
         wr(VEC_OFS, i);
         rd(VECADR_OFS);
         chk(d, v[i]);
      end
      wr(CTRL_OFS, 0);
      rd(VECADR_OFS);
      chk(d, 32'h0000_FFFE);
   endtask
   task automatic t_param();
      @(posedge aclk);
      param_we <= 1;
      param_addr <= 5;
      param_wdata <= 8'hA5;
      @(posedge aclk);
      param_addr <= 6;
      param_wdata <= 8'h3C;
      @(posedge aclk);
      param_we <= 0;
      rst();
      param_addr <= 5;
      repeat (2) @(posedge aclk);
      chk(param_rdata, 8'hA5);
      param_addr <= 6;
      repeat (2) @(posedge aclk);
      chk(param_rdata, 8'h3C);
   endtask
   initial begin
      #100000;
      bad_count++;
      summarize();
   end
   initial begin
      rst();
      t_reset();
      t_deep();
      t_ret();
      t_temp();
      t_map();
      t_vec();
      t_param();
      summarize();
   end
endmodule
